// ==== rtl/bcsm_consts.svh ====
// Constants for the battery charge state machine: offsets, fields, timing
`ifndef BCSM_CONSTS_SVH
`define BCSM_CONSTS_SVH

// Register byte offsets
`define BCSM_CTRL_OFS 12'h000
`define BCSM_STAT_OFS 12'h004
`define BCSM_CFG_OFS 12'h008

// Control register fields
`define BCSM_CTRL_EN_BIT 0
`define BCSM_CTRL_LFP_BIT 1
`define BCSM_CTRL_SUSP_BIT 2
`define BCSM_CTRL_RST 32'h0000_0001

// Configuration register: thermal foldback step in target code units
`define BCSM_CFG_RST 32'h0000_0004

// Target current codes
`define BCSM_I_ZERO 8'h00
`define BCSM_I_PRE 8'h10
`define BCSM_I_TRK 8'h20
`define BCSM_I_FC 8'hff

// Times in milliseconds and clock rate in kHz
`define BCSM_CLK_KHZ 100000
`define BCSM_T_PQ_MS 30
`define BCSM_T_FC_MS 21600000
`define BCSM_T_TERM_MS 1
`define BCSM_T_TO_MS 30

`define BCSM_RESP_OKAY 2'b00
`define BCSM_RESP_SLVERR 2'b10

`endif

// ==== rtl/bcsm_pkg.sv ====
// Types for the battery charge state machine
package bcsm_pkg;

    typedef enum logic [7:0] {
        BCSM_ST_INIT = 8'b0000_0001,
        BCSM_ST_PRE = 8'b0000_0010,
        BCSM_ST_TRK = 8'b0000_0100,
        BCSM_ST_CC = 8'b0000_1000,
        BCSM_ST_CV = 8'b0001_0000,
        BCSM_ST_TOP = 8'b0010_0000,
        BCSM_ST_DONE = 8'b0100_0000,
        BCSM_ST_FLT = 8'b1000_0000
    } bcsm_state_t;

    // Comparator results from the analog front end
    typedef struct packed {
        logic input_valid;
        logic above_precharge_threshold;
        logic above_trickle_threshold;
        logic above_battery_regulation_voltage;
        logic below_topoff_current;
        logic below_restart;
        logic above_thermal_regulation_threshold;
        logic at_input_current_floor;
        logic below_input_regulation_voltage;
        logic thermal_shutdown;
    } bcsm_cmp_t;

    // Targets to the analog loops
    typedef struct packed {
        logic [7:0] current_target;
        logic voltage_mode;
        logic input_switch_on;
        logic battery_feeds_system;
    } bcsm_tgt_t;

endpackage

// ==== rtl/bcsm_charger.sv ====
// Battery charge sequencing state machine with AXI4-Lite registers
`timescale 1ns/1ps
`include "bcsm_consts.svh"

module bcsm_charger
    import bcsm_pkg::*;
#(
    parameter int unsigned PQ_CYC = `BCSM_T_PQ_MS * `BCSM_CLK_KHZ,
    parameter longint unsigned FC_CYC =
        64'(`BCSM_T_FC_MS) * 64'(`BCSM_CLK_KHZ),
    parameter int unsigned TERM_CYC = `BCSM_T_TERM_MS * `BCSM_CLK_KHZ,
    parameter int unsigned TO_CYC = `BCSM_T_TO_MS * `BCSM_CLK_KHZ
)
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire bcsm_cmp_t cmp_in, // Asynchronous comparator levels
    output bcsm_tgt_t tgt_q // Targets for the analog loops
);

    bcsm_cmp_t cmp_m_q;
    bcsm_cmp_t cmp_q;
    bcsm_state_t state_q;
    bcsm_state_t state_d;
    logic [31:0] ctrl_q;
    logic [31:0] cfg_q;
    logic [63:0] phase_cnt_q;
    logic [31:0] term_cnt_q;
    logic input_off_q;
    logic valid_prev_q;
    logic phase_new;
    logic pq_over;
    logic fc_over;
    logic aw_hold_q;
    logic w_hold_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // Two-flop synchroniser for comparator levels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmp_m_q <= '0;
            cmp_q <= '0;
        end
        else
        begin
            cmp_m_q <= cmp_in;
            cmp_q <= cmp_m_q;
        end
    end

    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Write channel: address and data may arrive in either order
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BCSM_RESP_OKAY;
            ctrl_q <= `BCSM_CTRL_RST;
            cfg_q <= `BCSM_CFG_RST;
        end
        else if (aw_hold_q && w_hold_q)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_q[11:2] == `BCSM_CTRL_OFS / 4)
            begin
                ctrl_q <= merge_bytes(ctrl_q, w_data_q, w_strb_q);
                s_axi_bresp <= `BCSM_RESP_OKAY;
            end
            else if (aw_addr_q[11:2] == `BCSM_CFG_OFS / 4)
            begin
                cfg_q <= merge_bytes(cfg_q, w_data_q, w_strb_q);
                s_axi_bresp <= `BCSM_RESP_OKAY;
            end
            else if (aw_addr_q[11:2] == `BCSM_STAT_OFS / 4)
            begin
                s_axi_bresp <= `BCSM_RESP_OKAY;
            end
            else
            begin
                s_axi_bresp <= `BCSM_RESP_SLVERR;
            end
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BCSM_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `BCSM_RESP_OKAY;
            if (s_axi_araddr[11:2] == `BCSM_CTRL_OFS / 4)
            begin
                s_axi_rdata <= ctrl_q;
            end
            else if (s_axi_araddr[11:2] == `BCSM_STAT_OFS / 4)
            begin
                s_axi_rdata <= {13'h0000, cmp_q, input_off_q, state_q};
            end
            else if (s_axi_araddr[11:2] == `BCSM_CFG_OFS / 4)
            begin
                s_axi_rdata <= cfg_q;
            end
            else
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `BCSM_RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Input switch latch: off at floor, rearmed by input reinsertion
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            input_off_q <= 1'b0;
            valid_prev_q <= 1'b0;
        end
        else
        begin
            valid_prev_q <= cmp_q.input_valid;
            if (cmp_q.at_input_current_floor &&
                cmp_q.below_input_regulation_voltage)
            begin
                input_off_q <= 1'b1;
            end
            else if (cmp_q.input_valid && !valid_prev_q)
            begin
                input_off_q <= 1'b0;
            end
        end
    end

    assign phase_new = (state_d != state_q);
    // Precharge and trickle share one prequalification budget
    assign pq_over = (phase_cnt_q >= 64'(PQ_CYC));
    assign fc_over = (phase_cnt_q >= FC_CYC);

    // Next-state logic
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            BCSM_ST_INIT:
                if (cmp_q.input_valid && !input_off_q)
                    state_d = BCSM_ST_PRE;
            BCSM_ST_PRE:
                if (pq_over)
                    state_d = BCSM_ST_FLT;
                else if (cmp_q.above_precharge_threshold &&
                         ctrl_q[`BCSM_CTRL_LFP_BIT])
                    state_d = BCSM_ST_CC;
                else if (cmp_q.above_precharge_threshold)
                    state_d = BCSM_ST_TRK;
            BCSM_ST_TRK:
                if (pq_over)
                    state_d = BCSM_ST_FLT;
                else if (cmp_q.above_trickle_threshold)
                    state_d = BCSM_ST_CC;
            BCSM_ST_CC:
                if (fc_over)
                    state_d = BCSM_ST_FLT;
                else if (cmp_q.above_battery_regulation_voltage)
                    state_d = BCSM_ST_CV;
            BCSM_ST_CV:
                if (fc_over)
                    state_d = BCSM_ST_FLT;
                else if (term_cnt_q >= TERM_CYC)
                    state_d = BCSM_ST_TOP;
            BCSM_ST_TOP:
                if (cmp_q.below_restart)
                    state_d = BCSM_ST_CC;
                else if (phase_cnt_q >= 64'(TO_CYC))
                    state_d = BCSM_ST_DONE;
            BCSM_ST_DONE:
                if (cmp_q.below_restart)
                    state_d = BCSM_ST_CC;
            BCSM_ST_FLT:
                state_d = BCSM_ST_FLT;
            default:
                state_d = BCSM_ST_INIT;
        endcase
        // Thermal shutdown holds the present state
        if (cmp_q.thermal_shutdown)
            state_d = state_q;
        else if (!cmp_q.input_valid || input_off_q ||
                 ctrl_q[`BCSM_CTRL_SUSP_BIT] || !ctrl_q[`BCSM_CTRL_EN_BIT])
            state_d = BCSM_ST_INIT;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= BCSM_ST_INIT;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Phase timer restarts on every state change except PRE to TRK and CC to CV; those pairs share it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            phase_cnt_q <= 64'h0;
        end
        else if (state_q == BCSM_ST_INIT)
        begin
            phase_cnt_q <= 64'h0;
        end
        else if (phase_new && !(state_q == BCSM_ST_CC &&
                 state_d == BCSM_ST_CV) && !(state_q == BCSM_ST_PRE &&
                 state_d == BCSM_ST_TRK))
        begin
            phase_cnt_q <= 64'h0;
        end
        else if (!cmp_q.thermal_shutdown)
        begin
            phase_cnt_q <= phase_cnt_q + 64'h1;
        end
    end

    // Termination qualification counter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            term_cnt_q <= 32'h0;
        end
        else if (state_q != BCSM_ST_CV || !cmp_q.below_topoff_current)
        begin
            term_cnt_q <= 32'h0;
        end
        else if (term_cnt_q < TERM_CYC)
        begin
            term_cnt_q <= term_cnt_q + 32'h1;
        end
    end

    // Targets for the analog loops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tgt_q <= '{`BCSM_I_ZERO, 1'b0, 1'b0, 1'b1};
        end
        else
        begin
            tgt_q.input_switch_on <= !input_off_q && cmp_q.input_valid;
            tgt_q.voltage_mode <= (state_q == BCSM_ST_CV) ||
                (state_q == BCSM_ST_TOP);
            // Analog loop serves system first; this is only a ceiling
            tgt_q.battery_feeds_system <=
                (state_q == BCSM_ST_INIT);
            case (state_q)
                BCSM_ST_PRE:
                begin
                    tgt_q.current_target <= `BCSM_I_PRE;
                end
                BCSM_ST_TRK:
                begin
                    tgt_q.current_target <= `BCSM_I_TRK;
                end
                BCSM_ST_CC, BCSM_ST_CV, BCSM_ST_TOP:
                begin
                    if (cmp_q.above_thermal_regulation_threshold)
                    begin
                        tgt_q.current_target <= `BCSM_I_FC -
                            cfg_q[7:0];
                    end
                    else
                    begin
                        tgt_q.current_target <= `BCSM_I_FC;
                    end
                end
                default:
                begin
                    tgt_q.current_target <= `BCSM_I_ZERO;
                end
            endcase
        end
    end

endmodule

// ==== verification/bcsm_batt_model.sv ====
// Battery and comparator model facing the charger's analog side
`timescale 1ns/1ps

module bcsm_batt_model
    import bcsm_pkg::*;
(
    input wire logic [1:0] lv, // Battery band: 0 below precharge .. 3 at reg
    input wire logic plug, // Adapter attached and valid
    input wire logic hot, // Die above foldback point
    input wire logic topo, // Charge current below top-off level
    input wire logic flo, // Input loop at floor with input sagging
    output bcsm_cmp_t cmp // Comparator levels to the charger
);
    always_comb
    begin
        cmp.input_valid = plug;
        // Band 0 includes a dead pack at zero volts
        cmp.above_precharge_threshold = lv != 2'd0;
        cmp.above_trickle_threshold = lv >= 2'd2;
        cmp.above_battery_regulation_voltage = lv == 2'd3;
        cmp.below_topoff_current = topo;
        cmp.below_restart = 1'b0;
        cmp.above_thermal_regulation_threshold = hot;
        cmp.at_input_current_floor = flo;
        cmp.below_input_regulation_voltage = flo;
        cmp.thermal_shutdown = 1'b0;
    end
endmodule

// ==== verification/bcsm_charger_chk.sv ====
// Port-level assertions for the charge state machine
`timescale 1ns/1ps
`include "bcsm_consts.svh"

module bcsm_charger_chk
    import bcsm_pkg::*;
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp, // Read response
    input wire logic s_axi_rvalid, // Read valid
    input wire bcsm_cmp_t cmp_in, // Comparators
    input wire bcsm_tgt_t tgt_q // Targets
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_idle_zero;
        (!cmp_in.input_valid && !cmp_in.thermal_shutdown) [*5]
            |-> tgt_q.current_target == `BCSM_I_ZERO
            && tgt_q.battery_feeds_system;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("target not idle with input invalid");

    property p_input_off;
        (cmp_in.at_input_current_floor
            && cmp_in.below_input_regulation_voltage) [*5]
            |-> !tgt_q.input_switch_on;
    endproperty
    a_input_off: assert property (p_input_off)
        else $error("input switch still on at floor");

    property p_leave_idle;
        tgt_q.current_target != `BCSM_I_ZERO
            |-> $past(cmp_in.input_valid, 4);
    endproperty
    a_leave_idle: assert property (p_leave_idle)
        else $error("charging without valid input");

    property p_pre;
        tgt_q.current_target == `BCSM_I_PRE
            |-> !$past(cmp_in.above_precharge_threshold, 4);
    endproperty
    a_pre: assert property (p_pre)
        else $error("precharge current above threshold");

    property p_trk;
        tgt_q.current_target == `BCSM_I_TRK
            |-> $past(cmp_in.above_precharge_threshold, 4)
            && !$past(cmp_in.above_trickle_threshold, 4);
    endproperty
    a_trk: assert property (p_trk)
        else $error("trickle current outside its band");

    property p_cv;
        $rose(tgt_q.voltage_mode)
            |-> $past(cmp_in.above_battery_regulation_voltage, 4);
    endproperty
    a_cv: assert property (p_cv)
        else $error("voltage mode without regulation level");

    property p_fold;
        tgt_q.current_target == `BCSM_I_FC
            |-> !$past(cmp_in.above_thermal_regulation_threshold, 3);
    endproperty
    a_fold: assert property (p_fold)
        else $error("full fast current while hot");

    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr >= 12'h00c
            |=> s_axi_rvalid && s_axi_rresp == `BCSM_RESP_SLVERR
            && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
endmodule

bind bcsm_charger bcsm_charger_chk bcsm_charger_chk_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .cmp_in(cmp_in), .tgt_q(tgt_q));

// ==== verification/bcsm_tb.sv ====
// Self-checking bench for the charge state machine
`timescale 1ns/1ps
`include "bcsm_consts.svh"

module testbench;
    import bcsm_pkg::*;
    localparam int unsigned PQ = 40, FC = 80, TM = 5, TO = 30;
    typedef struct {
        logic [31:0] d, m;
        logic [1:0] r;
        logic [7:0] c;
        logic t;
    } bcsm_note_t;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, lv;
    logic plug, hot, topo, flo;
    logic [7:0] step;
    bcsm_cmp_t cmp;
    bcsm_tgt_t tgt;
    bcsm_note_t rq[$], nt;
    logic [1:0] bq[$];
    int n_errors = 0, n_compared = 0;

    bcsm_charger #(.PQ_CYC(PQ), .FC_CYC(FC), .TERM_CYC(TM), .TO_CYC(TO))
    bcsm_charger_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_in(cmp),
        .tgt_q(tgt));
    bcsm_batt_model bcsm_batt_model_inst (.lv(lv), .plug(plug), .hot(hot),
        .topo(topo), .flo(flo), .cmp(cmp));

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r);
        logic aw_p;
        logic w_p;
        bq.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        // Each half is released at the edge that takes it
        while (aw_p || w_p)
        begin
            @(posedge aclk);
            if (aw_p && awready === 1'b1)
            begin
                awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_p && wready === 1'b1)
            begin
                wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, m,
        input logic [1:0] r, input logic [7:0] c, input logic t);
        bcsm_note_t e;
        e = '{d, m, r, c, t};
        rq.push_back(e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    // State read: one-hot state, optionally the current target too
    task automatic st(input logic [7:0] s, c, input logic t);
        rd(`BCSM_STAT_OFS, 32'(s), 32'hff, `BCSM_RESP_OKAY, c, t);
    endtask

    // Flags are {plug, hot, topo, flo}; settle past the input sync chain
    task automatic drv(input logic [1:0] l, input logic [3:0] f);
        @(posedge aclk);
        lv <= l;
        {plug, hot, topo, flo} <= f;
        repeat (6) @(posedge aclk);
    endtask

    // Compares each bus answer with the oldest expectation
    always @(negedge aclk)
    begin
        if (rvalid === 1'b1 && rready === 1'b1)
        begin
            nt = rq.pop_front();
            check("rdata", rdata & nt.m, nt.d);
            check("rresp", 32'(rresp), 32'(nt.r));
            if (nt.t)
                check("target", 32'(tgt.current_target), 32'(nt.c));
        end
        if (bvalid === 1'b1 && bready === 1'b1)
            check("bresp", 32'(bresp), 32'(bq.pop_front()));
    end

    initial
    begin
        #100000;
        n_errors++;
        final_report();
    end

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, lv, plug, hot, topo, flo} = '0;
        void'($urandom(34));
        step = 8'($urandom_range(15, 1));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`BCSM_CTRL_OFS, `BCSM_CTRL_RST, '1, `BCSM_RESP_OKAY, 0, 0);
        rd(`BCSM_CFG_OFS, `BCSM_CFG_RST, '1, `BCSM_RESP_OKAY, 0, 0);
        st(BCSM_ST_INIT, `BCSM_I_ZERO, 1);
        rd(12'h00c, 32'h0, '1, `BCSM_RESP_SLVERR, 0, 0);
        wr(12'h00c, 32'h1, `BCSM_RESP_SLVERR);
        wr(`BCSM_STAT_OFS, '1, `BCSM_RESP_OKAY);
        st(BCSM_ST_INIT, 0, 0);
        $display("test registers done");
        wr(`BCSM_CFG_OFS, 32'(step), `BCSM_RESP_OKAY);
        drv(0, 4'b1000);
        st(BCSM_ST_PRE, `BCSM_I_PRE, 1);
        drv(1, 4'b1000);
        st(BCSM_ST_TRK, `BCSM_I_TRK, 1);
        drv(2, 4'b1000);
        st(BCSM_ST_CC, `BCSM_I_FC, 1);
        drv(2, 4'b1100);
        st(BCSM_ST_CC, `BCSM_I_FC - step, 1);
        drv(3, 4'b1000);
        st(BCSM_ST_CV, `BCSM_I_FC, 1);
        drv(3, 4'b1010);
        repeat (TM) @(posedge aclk);
        st(BCSM_ST_TOP, 0, 0);
        repeat (TO) @(posedge aclk);
        st(BCSM_ST_DONE, 0, 0);
        drv(3, 4'b0000);
        st(BCSM_ST_INIT, `BCSM_I_ZERO, 1);
        $display("test lithium sequence done");
        drv(0, 4'b1000);
        st(BCSM_ST_PRE, `BCSM_I_PRE, 1);
        wr(`BCSM_CTRL_OFS, 32'h5, `BCSM_RESP_OKAY);
        st(BCSM_ST_INIT, `BCSM_I_ZERO, 1);
        wr(`BCSM_CTRL_OFS, 32'h3, `BCSM_RESP_OKAY);
        st(BCSM_ST_PRE, `BCSM_I_PRE, 1);
        drv(1, 4'b1000);
        st(BCSM_ST_CC, `BCSM_I_FC, 1);
        repeat (FC) @(posedge aclk);
        st(BCSM_ST_FLT, `BCSM_I_ZERO, 1);
        drv(2, 4'b1000);
        st(BCSM_ST_FLT, `BCSM_I_ZERO, 1);
        drv(0, 4'b0000);
        drv(0, 4'b1000);
        st(BCSM_ST_PRE, `BCSM_I_PRE, 1);
        $display("test suspend and fast timeout done");
        wr(`BCSM_CTRL_OFS, 32'h1, `BCSM_RESP_OKAY);
        repeat (PQ) @(posedge aclk);
        st(BCSM_ST_FLT, `BCSM_I_ZERO, 1);
        drv(0, 4'b0000);
        drv(0, 4'b1001);
        rd(`BCSM_STAT_OFS, 32'h101, 32'h1ff, `BCSM_RESP_OKAY, 0, 1);
        $display("test prequal timeout and input floor done");
        final_report();
    end
endmodule
